// File: core/odc_pkg.sv
/*
 * odc_pkg: constants and types for the output divider configuration
 * register slice (channel 5 divider words, channel 6 configuration and
 * divider words).
 * Assumes a serial programming front end on the same clock that turns
 * host frames into single-cycle register read and write strobes.
 */
package odc_pkg;

    // ------------------------------------------------------------------
    // register port geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int NUM_CH = 2;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CH5_INT_DIV_FRAC_HIGH = 8'h0d;
    localparam logic [ADDR_W-1:0] OFF_CH5_FRAC_DIV_LOW = 8'h0e;
    localparam logic [ADDR_W-1:0] OFF_CH6_OUTPUT_CONFIG = 8'h0f;
    localparam logic [ADDR_W-1:0] OFF_CH6_INT_DIV_FRAC_HIGH = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_CH6_FRAC_DIV_LOW = 8'h11;
    // per channel lookup, index 0 is channel 5, index 1 is channel 6
    localparam logic [NUM_CH-1:0][ADDR_W-1:0] OFF_INT_HIGH =
        {OFF_CH6_INT_DIV_FRAC_HIGH, OFF_CH5_INT_DIV_FRAC_HIGH};
    localparam logic [NUM_CH-1:0][ADDR_W-1:0] OFF_FRAC_LOW =
        {OFF_CH6_FRAC_DIV_LOW, OFF_CH5_FRAC_DIV_LOW};

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int INT_MSB = 11;
    localparam int INT_LSB = 4;
    localparam int FHI_MSB = 3;
    localparam int FHI_LSB = 0;
    localparam int PRE_MSB = 12;
    localparam int PRE_LSB = 10;
    localparam int FRAC_EN_BIT = 9;
    localparam int SLEW_BIT = 8;
    localparam int NEG_BIT = 7;
    localparam int POS_BIT = 6;
    localparam int DRV_MSB = 4;
    localparam int DRV_LSB = 3;
    localparam int ENA_MSB = 2;
    localparam int ENA_LSB = 1;
    localparam int RAIL_BIT = 0;

    // writable bits; reserved positions are never stored
    localparam logic [DATA_W-1:0] MASK_INT_HIGH = 16'h0fff;
    localparam logic [DATA_W-1:0] MASK_FRAC_LOW = 16'hffff;
    localparam logic [DATA_W-1:0] MASK_CONFIG = 16'h1fdf;

    // reset values
    localparam logic [DATA_W-1:0] RST_INT_HIGH = 16'h0000;
    localparam logic [DATA_W-1:0] RST_FRAC_LOW = 16'h0000;
    localparam logic [DATA_W-1:0] RST_CONFIG = 16'h0000;
    localparam logic [DATA_W-1:0] READ_UNMAPPED = 16'h0000;

    // ------------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------------
    localparam logic [8:0] RATIO_STEP = 9'h001;
    localparam logic [19:0] FRACTION_NONE = 20'h00000;
    localparam logic [2:0] PRE_CODE_DIV2 = 3'h0;
    localparam logic [2:0] PRE_CODE_DIV3 = 3'h1;
    localparam logic [2:0] PRE_CODE_DIV1 = 3'h7;
    localparam logic [1:0] PRESCALE_BY1 = 2'h1;
    localparam logic [1:0] PRESCALE_BY2 = 2'h2;
    localparam logic [1:0] PRESCALE_BY3 = 2'h3;
    localparam logic [1:0] DRV_CODE_LVDS_A = 2'h0;
    localparam logic [1:0] DRV_CODE_LVDS_B = 2'h1;
    localparam logic [1:0] DRV_CODE_LVCMOS = 2'h2;
    localparam logic [1:0] DRV_CODE_HCSL = 2'h3;
    localparam logic [1:0] ENA_CODE_OFF = 2'h0;
    localparam logic [1:0] ENA_CODE_ON = 2'h1;
    localparam logic [1:0] ENA_CODE_LOW = 2'h2;
    localparam logic [1:0] ENA_CODE_HIGH = 2'h3;

    typedef enum logic [2:0] {
        DRV_LVDS = 3'b001,
        DRV_LVCMOS = 3'b010,
        DRV_HCSL = 3'b100
    } odc_driver_t;

    typedef enum logic [3:0] {
        OUT_OFF = 4'b0001,
        OUT_RUN = 4'b0010,
        OUT_LOW = 4'b0100,
        OUT_HIGH = 4'b1000
    } odc_out_state_t;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
    } odc_reg_req_t;

    typedef struct packed {
        logic [8:0] ratio;
        logic [19:0] fraction;
        logic fractionOn;
    } odc_div_t;

    typedef struct packed {
        logic [1:0] prescale;
        logic edgeRateSlow;
        logic negSideOn;
        logic posSideOn;
        odc_driver_t driverKind;
        odc_out_state_t outputState;
        logic railHigh;
    } odc_drive_t;

endpackage

// File: core/odc_output_divider_config_regs.sv
/*
 * odc_output_divider_config_regs: register slice holding the channel 5
 * integer and fractional divider words and the channel 6 output
 * configuration with its divider words, plus the decoded settings that
 * the output dividers and drivers consume.
 * Assumes the serial front end runs on clk and presents at most one
 * single-cycle read or write strobe per cycle; channel 5 fraction enable
 * lives in another slice and arrives here on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

// Contract
// - integer ratio is bits 11:4 plus one
// - fraction bits 19:16 in bits 3:0
// - fraction bits 15:0 in next register
// - prescale code 000/001/111 means 2/3/1
// - fraction off bypasses the prescaler
// - config bit 9 switches fraction on
// - config bit 8 selects slow edge
// - negative side needs positive side on
// - bits 4:3 select LVDS, LVCMOS, HCSL
// - bits 2:1 select off, run, low, high
// - bit 0 selects the output rail
module odc_output_divider_config_regs
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port from the serial front end
    input wire odc_pkg::odc_reg_req_t regReq,
    output logic [odc_pkg::DATA_W-1:0] rdData_ff,
    output logic rdValid_ff,
    // fraction enable of channel 5, held in its own configuration slice
    input wire logic ch5FractionOn,
    // decoded divider settings, index 0 channel 5, index 1 channel 6
    output odc_pkg::odc_div_t [odc_pkg::NUM_CH-1:0] chDiv_ff,
    // decoded channel 6 driver settings
    output odc_pkg::odc_drive_t ch6Drive_ff
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    // shared by every write enable and the read mux
    // a plain compare: unmapped offsets simply match nothing
    function automatic logic hitReg(
        input logic [odc_pkg::ADDR_W-1:0] addr,
        input logic [odc_pkg::ADDR_W-1:0] offset
    );
        hitReg = (addr == offset);
    endfunction

    logic [odc_pkg::NUM_CH-1:0][odc_pkg::DATA_W-1:0] intHigh_ff;
    logic [odc_pkg::NUM_CH-1:0][odc_pkg::DATA_W-1:0] fracLow_ff;
    logic [odc_pkg::DATA_W-1:0] ch6Config_ff;
    logic [odc_pkg::NUM_CH-1:0] fracOn;
    logic [odc_pkg::DATA_W-1:0] nxt_rdData;

    // channel 5 keeps its enable bit in the neighbouring slice; that level
    // arrives on clk, so it needs no synchroniser and no extra delay here
    assign fracOn[0] = ch5FractionOn;
    assign fracOn[1] = ch6Config_ff[odc_pkg::FRAC_EN_BIT];

    // ------------------------------------------------------------------
    // divider word storage and decode, one copy per channel
    // ------------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < odc_pkg::NUM_CH; ch++)
        begin : gen_chan
            // reserved bits are masked off so they always read back zero
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    intHigh_ff[ch] <= odc_pkg::RST_INT_HIGH;
                end
                else if (regReq.wrEn &&
                         hitReg(regReq.addr, odc_pkg::OFF_INT_HIGH[ch]))
                begin
                    intHigh_ff[ch] <= regReq.wrData &
                                      odc_pkg::MASK_INT_HIGH;
                end
            end

            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    fracLow_ff[ch] <= odc_pkg::RST_FRAC_LOW;
                end
                else if (regReq.wrEn &&
                         hitReg(regReq.addr, odc_pkg::OFF_FRAC_LOW[ch]))
                begin
                    fracLow_ff[ch] <= regReq.wrData &
                                      odc_pkg::MASK_FRAC_LOW;
                end
            end

            // the decode sits behind a flop so every output leaves a
            // register; the price is one extra cycle before a new ratio
            // or fraction reaches the divider
            // decoded values lag the register write by one cycle
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    chDiv_ff[ch].ratio <= odc_pkg::RATIO_STEP;
                    chDiv_ff[ch].fraction <= odc_pkg::FRACTION_NONE;
                    chDiv_ff[ch].fractionOn <= 1'b0;
                end
                else
                begin
                    chDiv_ff[ch].ratio <= {1'b0, intHigh_ff[ch][
                        odc_pkg::INT_MSB:odc_pkg::INT_LSB]} +
                        odc_pkg::RATIO_STEP;
                    chDiv_ff[ch].fractionOn <= fracOn[ch];
                    // a disabled fraction is forced to zero
                    if (fracOn[ch])
                    begin
                        chDiv_ff[ch].fraction <= {intHigh_ff[ch][
                            odc_pkg::FHI_MSB:odc_pkg::FHI_LSB],
                            fracLow_ff[ch]};
                    end
                    else
                    begin
                        chDiv_ff[ch].fraction <= odc_pkg::FRACTION_NONE;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // channel 6 output configuration
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ch6Config_ff <= odc_pkg::RST_CONFIG;
        end
        else if (regReq.wrEn &&
                 hitReg(regReq.addr, odc_pkg::OFF_CH6_OUTPUT_CONFIG))
        begin
            ch6Config_ff <= regReq.wrData & odc_pkg::MASK_CONFIG;
        end
    end

    // prescaler decode; reserved codes fall back to divide by one so a
    // bad write never stalls the divider chain
    // the bypass follows the enable bit alone, whatever code is stored
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ch6Drive_ff.prescale <= odc_pkg::PRESCALE_BY1;
        end
        else if (!ch6Config_ff[odc_pkg::FRAC_EN_BIT])
        begin
            ch6Drive_ff.prescale <= odc_pkg::PRESCALE_BY1;
        end
        else
        begin
            case (ch6Config_ff[odc_pkg::PRE_MSB:odc_pkg::PRE_LSB])
                odc_pkg::PRE_CODE_DIV2:
                    ch6Drive_ff.prescale <= odc_pkg::PRESCALE_BY2;
                odc_pkg::PRE_CODE_DIV3:
                    ch6Drive_ff.prescale <= odc_pkg::PRESCALE_BY3;
                odc_pkg::PRE_CODE_DIV1:
                    ch6Drive_ff.prescale <= odc_pkg::PRESCALE_BY1;
                default:
                    ch6Drive_ff.prescale <= odc_pkg::PRESCALE_BY1;
            endcase
        end
    end

    // edge rate, side enables and rail select
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ch6Drive_ff.edgeRateSlow <= 1'b0;
            ch6Drive_ff.posSideOn <= 1'b0;
            ch6Drive_ff.negSideOn <= 1'b0;
            ch6Drive_ff.railHigh <= 1'b0;
        end
        else
        begin
            ch6Drive_ff.edgeRateSlow <=
                ch6Config_ff[odc_pkg::SLEW_BIT];
            ch6Drive_ff.posSideOn <= ch6Config_ff[odc_pkg::POS_BIT];
            // negative side is held off unless positive side is on
            // the stored bit still reads back as written, so the host sees
            // its own value even while the gate keeps the side dark
            ch6Drive_ff.negSideOn <= ch6Config_ff[odc_pkg::NEG_BIT] &
                                     ch6Config_ff[odc_pkg::POS_BIT];
            ch6Drive_ff.railHigh <=
                ch6Config_ff[odc_pkg::RAIL_BIT];
        end
    end

    // driver kind; both low codes mean the same differential driver
    // the default arm is unreachable but keeps the case complete
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ch6Drive_ff.driverKind <= odc_pkg::DRV_LVDS;
        end
        else
        begin
            case (ch6Config_ff[odc_pkg::DRV_MSB:odc_pkg::DRV_LSB])
                odc_pkg::DRV_CODE_LVDS_A,
                odc_pkg::DRV_CODE_LVDS_B:
                    ch6Drive_ff.driverKind <= odc_pkg::DRV_LVDS;
                odc_pkg::DRV_CODE_LVCMOS:
                    ch6Drive_ff.driverKind <= odc_pkg::DRV_LVCMOS;
                odc_pkg::DRV_CODE_HCSL:
                    ch6Drive_ff.driverKind <= odc_pkg::DRV_HCSL;
                default:
                    ch6Drive_ff.driverKind <= odc_pkg::DRV_LVDS;
            endcase
        end
    end

    // output enable state
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ch6Drive_ff.outputState <= odc_pkg::OUT_OFF;
        end
        else
        begin
            case (ch6Config_ff[odc_pkg::ENA_MSB:odc_pkg::ENA_LSB])
                odc_pkg::ENA_CODE_OFF:
                    ch6Drive_ff.outputState <= odc_pkg::OUT_OFF;
                odc_pkg::ENA_CODE_ON:
                    ch6Drive_ff.outputState <= odc_pkg::OUT_RUN;
                odc_pkg::ENA_CODE_LOW:
                    ch6Drive_ff.outputState <= odc_pkg::OUT_LOW;
                odc_pkg::ENA_CODE_HIGH:
                    ch6Drive_ff.outputState <= odc_pkg::OUT_HIGH;
                default:
                    ch6Drive_ff.outputState <= odc_pkg::OUT_OFF;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read back
    // ------------------------------------------------------------------
    // unmapped offsets read zero so the front end always has an answer
    always_comb
    begin
        nxt_rdData = odc_pkg::READ_UNMAPPED;
        if (hitReg(regReq.addr, odc_pkg::OFF_CH5_INT_DIV_FRAC_HIGH))
        begin
            nxt_rdData = intHigh_ff[0];
        end
        else if (hitReg(regReq.addr, odc_pkg::OFF_CH5_FRAC_DIV_LOW))
        begin
            nxt_rdData = fracLow_ff[0];
        end
        else if (hitReg(regReq.addr, odc_pkg::OFF_CH6_OUTPUT_CONFIG))
        begin
            nxt_rdData = ch6Config_ff;
        end
        else if (hitReg(regReq.addr, odc_pkg::OFF_CH6_INT_DIV_FRAC_HIGH))
        begin
            nxt_rdData = intHigh_ff[1];
        end
        else if (hitReg(regReq.addr, odc_pkg::OFF_CH6_FRAC_DIV_LOW))
        begin
            nxt_rdData = fracLow_ff[1];
        end
    end

    // a read and a write to one offset in the same cycle return the old
    // value, since the mux looks at the registers before the edge
    // data holds until the next read strobe
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rdData_ff <= odc_pkg::READ_UNMAPPED;
            rdValid_ff <= 1'b0;
        end
        else
        begin
            rdValid_ff <= regReq.rdEn;
            if (regReq.rdEn)
            begin
                rdData_ff <= nxt_rdData;
            end
        end
    end

endmodule

`default_nettype wire

// File: bench/odc_regs_assertions.sv
/*
 * odc_regs_checker: port-level checks of the divider configuration slice.
 * Assumes single-cycle strobes and a decode two edges after a write.
 */
`timescale 1ns/1ps
`default_nettype none
module odc_regs_checker
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire odc_pkg::odc_reg_req_t regReq,
    input wire logic [odc_pkg::DATA_W-1:0] rdData_ff,
    input wire logic rdValid_ff,
    // channel 5 enable and decoded settings
    input wire logic ch5FractionOn,
    input wire odc_pkg::odc_div_t [odc_pkg::NUM_CH-1:0] chDiv_ff,
    input wire odc_pkg::odc_drive_t ch6Drive_ff
);
    // ----------------------------------------------------------------
    // write data history
    // ----------------------------------------------------------------
    logic [odc_pkg::DATA_W-1:0] wd1_ff;
    logic [odc_pkg::DATA_W-1:0] wd2_ff;

    // two stages so the data lines up with the decode latency
    always_ff @(posedge clk)
    begin
        wd1_ff <= regReq.wrData;
        wd2_ff <= wd1_ff;
    end

    // expected prescale; reserved codes settle on divide by one
    function automatic logic [1:0] preExp(input logic [15:0] v);
        case ({v[9], v[12:10]})
            4'h8: return odc_pkg::PRESCALE_BY2;
            4'h9: return odc_pkg::PRESCALE_BY3;
            default: return odc_pkg::PRESCALE_BY1;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence sWr(logic [7:0] a);
        regReq.wrEn && regReq.addr == a;
    endsequence

    AST_RATIO: assert property (sWr(odc_pkg::OFF_CH6_INT_DIV_FRAC_HIGH)
        |-> ##2 chDiv_ff[1].ratio == {1'b0, wd2_ff[11:4]} + 9'h001)
        else $error("ratio not field plus one");
    AST_FRAC_HIGH: assert property (
        sWr(odc_pkg::OFF_CH6_INT_DIV_FRAC_HIGH)
        |-> ##2 !chDiv_ff[1].fractionOn
        || chDiv_ff[1].fraction[19:16] == wd2_ff[3:0])
        else $error("fraction top nibble wrong");
    AST_FRAC_LOW: assert property (sWr(odc_pkg::OFF_CH5_FRAC_DIV_LOW)
        |-> ##2 !chDiv_ff[0].fractionOn
        || chDiv_ff[0].fraction[15:0] == wd2_ff)
        else $error("fraction low half wrong");
    AST_FRAC_OFF: assert property (
        (chDiv_ff[0].fractionOn || chDiv_ff[0].fraction == 20'h00000)
        && (chDiv_ff[1].fractionOn || chDiv_ff[1].fraction == 20'h00000))
        else $error("fraction kept while disabled");
    AST_BYPASS: assert property (!chDiv_ff[1].fractionOn
        |-> ch6Drive_ff.prescale == odc_pkg::PRESCALE_BY1)
        else $error("prescaler not bypassed");
    AST_PRESCALE: assert property (sWr(odc_pkg::OFF_CH6_OUTPUT_CONFIG)
        |-> ##2 ch6Drive_ff.prescale == preExp(wd2_ff))
        else $error("prescale decode wrong");
    AST_CFG_BITS: assert property (
        sWr(odc_pkg::OFF_CH6_OUTPUT_CONFIG)
        |-> ##2 {chDiv_ff[1].fractionOn, ch6Drive_ff.edgeRateSlow,
        ch6Drive_ff.railHigh} == {wd2_ff[9], wd2_ff[8], wd2_ff[0]})
        else $error("config bit decode wrong");
    AST_SIDES: assert property (sWr(odc_pkg::OFF_CH6_OUTPUT_CONFIG)
        |-> ##2 {ch6Drive_ff.negSideOn, ch6Drive_ff.posSideOn}
        == {wd2_ff[7] && wd2_ff[6], wd2_ff[6]})
        else $error("side enables wrong");
    AST_DRIVER: assert property (sWr(odc_pkg::OFF_CH6_OUTPUT_CONFIG)
        |-> ##2 ch6Drive_ff.driverKind == (wd2_ff[4] ? (wd2_ff[3]
        ? odc_pkg::DRV_HCSL : odc_pkg::DRV_LVCMOS) : odc_pkg::DRV_LVDS))
        else $error("driver kind wrong");
    AST_OUT_STATE: assert property (
        sWr(odc_pkg::OFF_CH6_OUTPUT_CONFIG)
        |-> ##2 ch6Drive_ff.outputState == (4'h1 << wd2_ff[2:1]))
        else $error("output state wrong");
    AST_RATIO5: assert property (
        sWr(odc_pkg::OFF_CH5_INT_DIV_FRAC_HIGH)
        |-> ##2 chDiv_ff[0].ratio == {1'b0, wd2_ff[11:4]} + 9'h001)
        else $error("channel 5 ratio not field plus one");
    // a read answers on the next edge, for one cycle, and then holds
    AST_RD_VALID: assert property (regReq.rdEn |=> rdValid_ff)
        else $error("read answer missing");
    AST_RD_IDLE: assert property (!regReq.rdEn |=> !rdValid_ff)
        else $error("read answer without a strobe");
    AST_RD_HOLD: assert property (!regReq.rdEn |=> $stable(rdData_ff))
        else $error("read data moved without a strobe");
endmodule

bind odc_output_divider_config_regs odc_regs_checker chk
(
    .clk(clk),
    .rst_n(rst_n),
    .regReq(regReq),
    .rdData_ff(rdData_ff),
    .rdValid_ff(rdValid_ff),
    .ch5FractionOn(ch5FractionOn),
    .chDiv_ff(chDiv_ff),
    .ch6Drive_ff(ch6Drive_ff)
);
`default_nettype wire

// File: bench/odc_host_model.sv
/*
 * odc_host_model: host side of the serial front end, as strobes.
 * Assumes requests launch on falling edges of the slice clock.
 */
`timescale 1ns/1ps
`default_nettype none
module odc_host_model
(
    // clock
    input wire logic clk,
    // register port toward the slice
    output odc_pkg::odc_reg_req_t regReq,
    input wire logic [odc_pkg::DATA_W-1:0] rdData_ff,
    input wire logic rdValid_ff
);
    initial regReq = '0;

    // one write; address and data flip after release so stale values die
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        regReq.wrEn = 1'b1;
        regReq.addr = a;
        regReq.wrData = d;
        @(negedge clk);
        regReq.wrEn = 1'b0;
        regReq.addr = ~a;
        regReq.wrData = ~d;
    endtask

    // one read; answer is taken once the strobe edge has passed
    task automatic rd(input logic [7:0] a, output logic [15:0] d,
                      output logic v);
        @(negedge clk);
        regReq.rdEn = 1'b1;
        regReq.addr = a;
        @(negedge clk);
        d = rdData_ff;
        v = rdValid_ff;
        regReq.rdEn = 1'b0;
        regReq.addr = ~a;
    endtask
endmodule
`default_nettype wire

// File: bench/odc_output_divider_config_regs_tb_top.sv
/*
 * odc_output_divider_config_regs_tb_top: directed register tests.
 * Assumes the host model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none
module odc_output_divider_config_regs_tb_top;
    logic clk;
    logic rst_n;
    logic ch5FractionOn;
    odc_pkg::odc_reg_req_t regReq;
    logic [15:0] rdData_ff;
    logic rdValid_ff;
    odc_pkg::odc_div_t [odc_pkg::NUM_CH-1:0] chDiv_ff;
    odc_pkg::odc_drive_t ch6Drive_ff;
    int nErrors = 0;
    int numChecks = 0;
    logic [15:0] rv;
    logic vld;
    logic [15:0] cv;
    logic [2:0] pre [5] = '{3'h0, 3'h1, 3'h7, 3'h2, 3'h1};
    logic [1:0] pexp [5] = '{2'h2, 2'h3, 2'h1, 2'h1, 2'h1};
    logic [2:0] dexp [4] = '{3'h1, 3'h1, 3'h2, 3'h4};

    odc_output_divider_config_regs dut
    (
        .clk(clk),
        .rst_n(rst_n),
        .regReq(regReq),
        .rdData_ff(rdData_ff),
        .rdValid_ff(rdValid_ff),
        .ch5FractionOn(ch5FractionOn),
        .chDiv_ff(chDiv_ff),
        .ch6Drive_ff(ch6Drive_ff)
    );

    odc_host_model host
    (
        .clk(clk),
        .regReq(regReq),
        .rdData_ff(rdData_ff),
        .rdValid_ff(rdValid_ff)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        numChecks++;
        if (g !== e)
        begin
            nErrors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [15:0] e);
        host.rd(a, rv, vld);
        chk("rdValid", 32'h1, 32'(vld));
        chk("rdData", 32'(e), 32'(rv));
    endtask

    task automatic tallyAndFinish();
        $display("checks %0d mismatches %0d", numChecks, nErrors);
        if (nErrors == 0 && numChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // free running 8 ns clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // hang guard, far beyond the roughly 56 cycles the tests need
    initial
    begin
        #80000;
        nErrors++;
        tallyAndFinish();
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        ch5FractionOn = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        // every mapped register starts at zero
        for (int i = 8'h0d; i <= 8'h11; i++)
            rdChk(8'(i), 16'h0000);
        chk("state", 32'(odc_pkg::OUT_OFF),
            32'(ch6Drive_ff.outputState));
        // top ratio code with reserved bits set by a faulty host
        host.wr(odc_pkg::OFF_CH6_INT_DIV_FRAC_HIGH, 16'hffff);
        rdChk(odc_pkg::OFF_CH6_INT_DIV_FRAC_HIGH, 16'h0fff);
        chk("ratio6", 32'h100, 32'(chDiv_ff[1].ratio));
        // channel 5 fraction on first, so the low half check has teeth
        ch5FractionOn = 1'b1;
        host.wr(odc_pkg::OFF_CH5_INT_DIV_FRAC_HIGH, 16'h0ab3);
        host.wr(odc_pkg::OFF_CH5_FRAC_DIV_LOW, 16'h5678);
        host.wr(odc_pkg::OFF_CH6_FRAC_DIV_LOW, 16'h1234);
        @(negedge clk);
        chk("fon5", 32'h1, 32'(chDiv_ff[0].fractionOn));
        chk("ratio5", 32'h0ac, 32'(chDiv_ff[0].ratio));
        chk("frac5", 32'h35678, 32'(chDiv_ff[0].fraction));
        chk("frac6", 32'h0, 32'(chDiv_ff[1].fraction));
        // sweep prescale, driver and enable codes; last pass fraction off
        for (int i = 0; i < 5; i++)
        begin
            cv = {3'h7, pre[i], (i < 4), i[0], 1'b1, i[0], 1'b1,
                  i[1:0], i[1:0], i[0]};
            host.wr(odc_pkg::OFF_CH6_OUTPUT_CONFIG, cv);
            // same word again while the fraction is on, so the top nibble
            // path is seen live
            if (i == 0)
                host.wr(odc_pkg::OFF_CH6_INT_DIV_FRAC_HIGH, 16'h0fff);
            rdChk(odc_pkg::OFF_CH6_OUTPUT_CONFIG, cv & 16'h1fdf);
            chk("pre", 32'(pexp[i]), 32'(ch6Drive_ff.prescale));
            chk("fon", 32'(i < 4), 32'(chDiv_ff[1].fractionOn));
            chk("slow", 32'(i[0]), 32'(ch6Drive_ff.edgeRateSlow));
            chk("pos", 32'(i[0]), 32'(ch6Drive_ff.posSideOn));
            chk("neg", 32'(i[0]), 32'(ch6Drive_ff.negSideOn));
            chk("drv", 32'(dexp[i % 4]), 32'(ch6Drive_ff.driverKind));
            chk("ena", 32'(4'h1 << i[1:0]),
                32'(ch6Drive_ff.outputState));
            chk("rail", 32'(i[0]), 32'(ch6Drive_ff.railHigh));
            chk("frac6", (i < 4) ? 32'hf1234 : 32'h0,
                32'(chDiv_ff[1].fraction));
        end
        ch5FractionOn = 1'b0;
        @(negedge clk);
        chk("frac5", 32'h0, 32'(chDiv_ff[0].fraction));
        // unmapped place: write dropped, read gives zero
        host.wr(8'h12, 16'hbeef);
        rdChk(8'h12, 16'h0000);
        rdChk(odc_pkg::OFF_CH6_FRAC_DIV_LOW, 16'h1234);
        // second reset in mid run
        @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        rdChk(odc_pkg::OFF_CH6_OUTPUT_CONFIG, 16'h0000);
        chk("ratio6", 32'h001, 32'(chDiv_ff[1].ratio));
        chk("state", 32'(odc_pkg::OUT_OFF),
            32'(ch6Drive_ff.outputState));
        tallyAndFinish();
    end
endmodule
`default_nettype wire
